// ---- fsc_cfg.svh ----
// Constants of the flash status and configuration register block.
// Assumes a 40 MHz core clock and a host driving mode-0 serial frames.
`ifndef FSC_CFG_SVH
`define FSC_CFG_SVH

// Command opcodes
`define FSC_OP_READ_STATUS 8'h05
`define FSC_OP_WRITE_STATUS 8'h01
`define FSC_OP_WRITE_ENABLE 8'h06
`define FSC_OP_PAGE_PROGRAM 8'h02
`define FSC_OP_SECTOR_ERASE 8'h20
`define FSC_OP_HALF_BLOCK_ERASE 8'h52
`define FSC_OP_BLOCK_ERASE 8'hD8
`define FSC_OP_CHIP_ERASE 8'h60

// Frame lengths in serial clock bits, opcode included
`define FSC_BITS_OPCODE 8'h08
`define FSC_BITS_WRITE_STATUS_CMD_SHORT 8'h10
`define FSC_BITS_WRITE_STATUS_CMD_LONG 8'h18
`define FSC_BITS_ADDRESSED 8'h20

// Status and configuration field positions
`define FSC_ST_BUSY 0
`define FSC_ST_WEL 1
`define FSC_CF_BOTTOM 3
`define FSC_CF_DUMMY 6

// Reset values
`define FSC_STATUS_RESET 8'h00
`define FSC_CONFIG_RESET 8'h00

// Dummy cycle counts
`define FSC_DUAL_DUMMY_LO 4'h4
`define FSC_DUAL_DUMMY_HI 4'h8
`define FSC_QUAD_DUMMY_LO 4'h6
`define FSC_QUAD_DUMMY_HI 4'hA

// Status-write cycle time
`define FSC_CLK_NS 25
`define FSC_TW_NS 10000
`define FSC_TW_CYCLES ((`FSC_TW_NS + `FSC_CLK_NS - 1) / `FSC_CLK_NS)

`endif

// ---- fsc_host.sv ----
// SPI host model that frames commands for the flash register block.
// Assumes mode 0, serial clock running only inside frames, idle low.
`timescale 1ns/1ps

module fsc_host
(
    input wire logic i_so,
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_si
);
    // Half period of the serial clock; raise it to act as a slow host
    int half = 80;

    initial
    begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_si = 1'b0;
    end

    // ********************************
    // Frame: n bits of d, MSB first
    // ********************************
    task automatic xfer(input int n, input logic [31:0] d, output logic [31:0] rx);
        rx = 32'h0;
        o_cs_n = 1'b0;
        #(2 * half);
        for (int i = 0; i < n; i++)
        begin
            o_si = d[31 - i];
            #half;
            o_sclk = 1'b1;
            rx = {rx[30:0], i_so};
            #half;
            o_sclk = 1'b0;
        end
        #half;
        o_cs_n = 1'b1;
        // Released data line must not keep the last bit
        o_si = ~o_si;
        #300;
    endtask
endmodule

// ---- fsc_pkg.sv ----
// Types shared by the flash status and configuration register block.
// Assumes fsc_cfg.svh carries all numeric constants.
package fsc_pkg;

    // Gray codes: idle -> check -> program/erase, idle -> status write -> idle
    typedef enum logic [1:0]
    {
        FSC_IDLE = 2'b00,
        FSC_CHECK = 2'b01,
        FSC_PE_RUN = 2'b11,
        FSC_WSR_RUN = 2'b10
    } fsc_state_t;

    typedef struct packed
    {
        logic status_lock_bit;
        logic quad_io_enable;
        logic [3:0] protect_level;
        logic write_enable_latch;
        logic write_busy_flag;
    } fsc_status_t;

    typedef struct packed
    {
        logic [7:0] opcode;
        logic [23:0] payload;
        logic [7:0] bits;
    } fsc_frame_t;

    typedef struct packed
    {
        logic dummy_select;
        logic protect_from_bottom;
    } fsc_config_t;

endpackage

// ---- fsc_regs.sv ----
// Status and configuration registers of a serial NOR flash with link decoder.
// Assumes program/erase engine and protected-area decode sit outside this block.
`timescale 1ns/1ps
`include "fsc_cfg.svh"

module fsc_regs
    import fsc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_si,
    input wire logic i_write_protect_or_lane2,
    input wire logic i_pause_or_lane3,
    input wire logic i_pe_protected,
    input wire logic i_pe_done,
    output logic o_so,
    output logic o_so_oe_n,
    output fsc_status_t o_status,
    output fsc_config_t o_config,
    output logic o_pe_start,
    output logic [7:0] o_pe_cmd,
    output logic [23:0] o_pe_addr,
    output logic o_hardware_lock_mode,
    output logic o_pause_active,
    output logic [3:0] o_dual_dummy,
    output logic [3:0] o_quad_dummy
);

    // ****************************************************
    // Link domain: opcode and payload capture
    // ****************************************************
    logic link_rst;
    logic [7:0] cnt;
    logic [7:0] next_cnt;
    fsc_frame_t frame;
    fsc_frame_t next_frame;
    logic frame_tgl;
    logic next_frame_tgl;
    logic [7:0] st_s1;
    logic [7:0] st_s2;
    logic [7:0] snap;
    logic [7:0] next_snap;
    logic [7:0] status_word;

    // Select high ends the frame, so the bit counter needs no clock edge after it
    assign link_rst = i_rst | i_cs_n;

    always_comb
    begin
        next_cnt = (cnt == 8'hFF) ? cnt : cnt + 8'h01;
    end

    always_ff @(posedge i_sclk or posedge link_rst)
    begin
        if (link_rst)
        begin
            cnt <= 8'h00;
        end
        else
        begin
            cnt <= next_cnt;
        end
    end

    always_comb
    begin
        next_frame = frame;
        next_frame_tgl = frame_tgl;
        next_snap = snap;
        if (cnt == 8'h00)
        begin
            next_frame_tgl = ~frame_tgl;
            next_frame.payload = 24'h000000;
        end
        if (cnt < `FSC_BITS_OPCODE)
        begin
            next_frame.opcode = {frame.opcode[6:0], i_si};
        end
        else if (cnt < `FSC_BITS_ADDRESSED)
        begin
            next_frame.payload = {frame.payload[22:0], i_si};
        end
        next_frame.bits = next_cnt;
        // Fresh status at each byte boundary keeps a byte self-consistent
        if (cnt[2:0] == 3'h7)
        begin
            next_snap = st_s2;
        end
    end

    // Frame record is not cleared by select, the core reads it after select rises
    always_ff @(posedge i_sclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            frame <= '0;
            frame_tgl <= 1'b0;
            snap <= `FSC_STATUS_RESET;
            st_s1 <= `FSC_STATUS_RESET;
            st_s2 <= `FSC_STATUS_RESET;
        end
        else
        begin
            frame <= next_frame;
            frame_tgl <= next_frame_tgl;
            snap <= next_snap;
            st_s1 <= status_word;
            st_s2 <= st_s1;
        end
    end

    // ****************************************************
    // Link domain: status byte shift-out
    // ****************************************************
    logic next_so;
    logic next_so_oe_n;

    always_comb
    begin
        next_so = 1'b0;
        next_so_oe_n = 1'b1;
        if ((cnt >= `FSC_BITS_OPCODE) && (frame.opcode == `FSC_OP_READ_STATUS))
        begin
            next_so = snap[~cnt[2:0]];
            next_so_oe_n = 1'b0;
        end
    end

    always_ff @(negedge i_sclk or posedge link_rst)
    begin
        if (link_rst)
        begin
            o_so <= 1'b0;
            o_so_oe_n <= 1'b1;
        end
        else
        begin
            o_so <= next_so;
            o_so_oe_n <= next_so_oe_n;
        end
    end

    // ****************************************************
    // Core domain: synchronisers
    // ****************************************************
    logic cs_s1;
    logic cs_s2;
    logic cs_s3;
    logic tgl_s1;
    logic tgl_s2;
    logic tgl_seen;
    logic wp_s1;
    logic wp_s2;
    logic hold_s1;
    logic hold_s2;
    logic frame_end;

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
            cs_s3 <= 1'b1;
            tgl_s1 <= 1'b0;
            tgl_s2 <= 1'b0;
            tgl_seen <= 1'b0;
            wp_s1 <= 1'b1;
            wp_s2 <= 1'b1;
            hold_s1 <= 1'b1;
            hold_s2 <= 1'b1;
        end
        else
        begin
            cs_s1 <= i_cs_n;
            cs_s2 <= cs_s1;
            cs_s3 <= cs_s2;
            tgl_s1 <= frame_tgl;
            tgl_s2 <= tgl_s1;
            tgl_seen <= (cs_s2 & ~cs_s3) ? tgl_s2 : tgl_seen;
            wp_s1 <= i_write_protect_or_lane2;
            wp_s2 <= wp_s1;
            hold_s1 <= i_pause_or_lane3;
            hold_s2 <= hold_s1;
        end
    end

    // Frame record is stable here: select is high and the serial clock idles
    assign frame_end = cs_s2 & ~cs_s3 & (tgl_s2 != tgl_seen);

    // ****************************************************
    // Core domain: registers and cycle control
    // ****************************************************
    fsc_state_t state;
    fsc_state_t next_state;
    fsc_status_t next_status;
    fsc_config_t next_config;
    logic [15:0] timer;
    logic [15:0] next_timer;
    logic [7:0] pend_status;
    logic [7:0] next_pend_status;
    logic [7:0] pend_config;
    logic [7:0] next_pend_config;
    logic pend_long;
    logic next_pend_long;
    logic next_pe_start;
    logic [7:0] next_pe_cmd;
    logic [23:0] next_pe_addr;
    logic is_pe_op;

    assign is_pe_op = (frame.opcode == `FSC_OP_PAGE_PROGRAM)
        || (frame.opcode == `FSC_OP_SECTOR_ERASE)
        || (frame.opcode == `FSC_OP_HALF_BLOCK_ERASE)
        || (frame.opcode == `FSC_OP_BLOCK_ERASE);

    // Quad mode overrides the pin alternate functions
    assign o_hardware_lock_mode = o_status.status_lock_bit & ~wp_s2
        & ~o_status.quad_io_enable;
    assign o_pause_active = ~hold_s2 & ~o_status.quad_io_enable;
    assign o_dual_dummy = o_config.dummy_select ? `FSC_DUAL_DUMMY_HI
        : `FSC_DUAL_DUMMY_LO;
    assign o_quad_dummy = o_config.dummy_select ? `FSC_QUAD_DUMMY_HI
        : `FSC_QUAD_DUMMY_LO;
    assign status_word = o_status;

    always_comb
    begin
        next_state = state;
        next_status = o_status;
        next_config = o_config;
        next_timer = timer;
        next_pend_status = pend_status;
        next_pend_config = pend_config;
        next_pend_long = pend_long;
        next_pe_start = 1'b0;
        next_pe_cmd = o_pe_cmd;
        next_pe_addr = o_pe_addr;
        unique case (state)
            FSC_IDLE:
            begin
                if (frame_end)
                begin
                    if ((frame.opcode == `FSC_OP_WRITE_ENABLE)
                        && (frame.bits == `FSC_BITS_OPCODE))
                    begin
                        next_status.write_enable_latch = 1'b1;
                    end
                    else if ((frame.opcode == `FSC_OP_WRITE_STATUS)
                        && o_status.write_enable_latch && !o_hardware_lock_mode
                        && ((frame.bits == `FSC_BITS_WRITE_STATUS_CMD_SHORT)
                        || (frame.bits == `FSC_BITS_WRITE_STATUS_CMD_LONG)))
                    begin
                        next_pend_long = (frame.bits == `FSC_BITS_WRITE_STATUS_CMD_LONG);
                        next_pend_status = next_pend_long ? frame.payload[15:8]
                            : frame.payload[7:0];
                        next_pend_config = frame.payload[7:0];
                        next_timer = 16'(`FSC_TW_CYCLES);
                        next_state = FSC_WSR_RUN;
                    end
                    else if (o_status.write_enable_latch)
                    begin
                        if (frame.opcode == `FSC_OP_CHIP_ERASE)
                        begin
                            if (o_status.protect_level == 4'h0)
                            begin
                                next_pe_cmd = frame.opcode;
                                next_pe_start = 1'b1;
                                next_state = FSC_PE_RUN;
                            end
                            else
                            begin
                                next_status.write_enable_latch = 1'b0;
                            end
                        end
                        else if (is_pe_op && (frame.bits >= `FSC_BITS_ADDRESSED))
                        begin
                            next_pe_cmd = frame.opcode;
                            next_pe_addr = frame.payload;
                            next_state = FSC_CHECK;
                        end
                    end
                end
            end
            FSC_CHECK:
            begin
                if (i_pe_protected)
                begin
                    next_status.write_enable_latch = 1'b0;
                    next_state = FSC_IDLE;
                end
                else
                begin
                    next_pe_start = 1'b1;
                    next_state = FSC_PE_RUN;
                end
            end
            FSC_PE_RUN:
            begin
                if (i_pe_done)
                begin
                    next_status.write_enable_latch = 1'b0;
                    next_state = FSC_IDLE;
                end
            end
            FSC_WSR_RUN:
            begin
                next_timer = timer - 16'h0001;
                if (timer == 16'h0001)
                begin
                    next_status.status_lock_bit = pend_status[7];
                    next_status.quad_io_enable = pend_status[6];
                    next_status.protect_level = pend_status[5:2];
                    next_status.write_enable_latch = 1'b0;
                    if (pend_long)
                    begin
                        next_config.dummy_select = pend_config[`FSC_CF_DUMMY];
                        // One-time bit: can only be set
                        next_config.protect_from_bottom = o_config.protect_from_bottom
                            | pend_config[`FSC_CF_BOTTOM];
                    end
                    next_state = FSC_IDLE;
                end
            end
        endcase
        next_status.write_busy_flag = (next_state == FSC_PE_RUN)
            || (next_state == FSC_WSR_RUN);
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state <= FSC_IDLE;
            o_status <= `FSC_STATUS_RESET;
            o_config <= '0;
            timer <= 16'h0000;
            pend_status <= `FSC_STATUS_RESET;
            pend_config <= `FSC_CONFIG_RESET;
            pend_long <= 1'b0;
            o_pe_start <= 1'b0;
            o_pe_cmd <= 8'h00;
            o_pe_addr <= 24'h000000;
        end
        else
        begin
            state <= next_state;
            o_status <= next_status;
            o_config <= next_config;
            timer <= next_timer;
            pend_status <= next_pend_status;
            pend_config <= next_pend_config;
            pend_long <= next_pend_long;
            o_pe_start <= next_pe_start;
            o_pe_cmd <= next_pe_cmd;
            o_pe_addr <= next_pe_addr;
        end
    end

    // ****************************************************
    // Assertions
    // ****************************************************
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    a_wsr_busy_hold: assert property ($rose(state == FSC_WSR_RUN) |-> o_status.write_busy_flag [*8])
        else $error("busy flag dropped early in status write");
    a_wsr_end_clear: assert property ($fell(state == FSC_WSR_RUN) |-> !o_status.write_enable_latch && !o_status.write_busy_flag)
        else $error("status write end left latch or busy set");
    a_pe_done_clear: assert property (state == FSC_PE_RUN && i_pe_done |=> !o_status.write_enable_latch && !o_status.write_busy_flag)
        else $error("program or erase end did not clear latch");
    a_pe_needs_wel: assert property (o_pe_start |-> $past(o_status.write_enable_latch))
        else $error("program or erase started without latch");
    a_ce_unprotected: assert property (o_pe_start && o_pe_cmd == `FSC_OP_CHIP_ERASE |-> o_status.protect_level == 4'h0)
        else $error("chip erase started with protection set");
    a_prot_reject: assert property (state == FSC_CHECK && i_pe_protected |=> !o_status.write_enable_latch && !o_pe_start ##1 !o_pe_start)
        else $error("protected area command not rejected");
    a_lock_no_write: assert property (state == FSC_IDLE && frame_end && o_hardware_lock_mode
        |=> state != FSC_WSR_RUN)
        else $error("status write accepted in lock mode");
    a_quad_no_lock: assert property (o_status.quad_io_enable |-> !o_hardware_lock_mode && !o_pause_active)
        else $error("lock or pause active in quad mode");
    a_write_enable_cmd_sets: assert property (state == FSC_IDLE && frame_end && frame.opcode == `FSC_OP_WRITE_ENABLE && frame.bits == `FSC_BITS_OPCODE |=> o_status.write_enable_latch)
        else $error("write enable did not set latch");
    a_nv_stable: assert property (!(state == FSC_WSR_RUN && timer == 16'h0001) |=> $stable(o_status[7:2]))
        else $error("protect bits changed outside status write");
    a_busy_flag: assert property (o_status.write_busy_flag == (state == FSC_PE_RUN || state == FSC_WSR_RUN))
        else $error("busy flag does not match running cycle");

    c_wsr_done: cover property ($fell(state == FSC_WSR_RUN));
    c_pe_start: cover property (o_pe_start);
    c_prot_reject: cover property (state == FSC_CHECK && i_pe_protected);
    c_lock_mode: cover property (frame_end && o_hardware_lock_mode);

endmodule

// ---- tb.sv ----
// Self-checking bench for the flash status and configuration registers.
// Assumes fsc_host drives the serial link and the bench plays the engine.
`timescale 1ns/1ps
`include "fsc_cfg.svh"

module tb import fsc_pkg::*;;
    logic i_clk, i_rst, i_wp, i_pause, i_prot, i_done;
    logic sclk, cs_n, si, so, so_oe_n, pe_start, lock, pause_act;
    fsc_status_t st;
    fsc_config_t cf;
    logic [7:0] pe_cmd, s, c;
    logic [23:0] pe_addr;
    logic [3:0] dd, qd;
    logic [31:0] rx;
    logic exp_bot, exp_dc;
    logic [7:0] ops [4] = '{`FSC_OP_PAGE_PROGRAM, `FSC_OP_SECTOR_ERASE,
        `FSC_OP_HALF_BLOCK_ERASE, `FSC_OP_BLOCK_ERASE};
    int n_fail, total_checks;
    int n_start = 0;

    fsc_regs u_fsc_regs (.i_clk(i_clk), .i_rst(i_rst), .i_sclk(sclk), .i_cs_n(cs_n),
        .i_si(si), .i_write_protect_or_lane2(i_wp), .i_pause_or_lane3(i_pause),
        .i_pe_protected(i_prot), .i_pe_done(i_done), .o_so(so), .o_so_oe_n(so_oe_n),
        .o_status(st), .o_config(cf), .o_pe_start(pe_start), .o_pe_cmd(pe_cmd),
        .o_pe_addr(pe_addr), .o_hardware_lock_mode(lock), .o_pause_active(pause_act),
        .o_dual_dummy(dd), .o_quad_dummy(qd));
    // Released data line is pulled high
    fsc_host u_fsc_host (.i_so(so_oe_n ? 1'b1 : so), .o_sclk(sclk), .o_cs_n(cs_n), .o_si(si));

    initial
    begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end

    always @(posedge i_clk)
        if (pe_start === 1'b1)
            n_start <= n_start + 1;

    // ********************************
    // Checking and link helpers
    // ********************************
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks=%0d fails=%0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    function automatic logic [7:0] dummies(input logic dc);
        return dc ? 8'h8A : 8'h46;
    endfunction

    task automatic cmd(input int n, input logic [31:0] d);
        u_fsc_host.xfer(n, d, rx);
    endtask

    task automatic rd();
        cmd(24, {`FSC_OP_READ_STATUS, 24'h0});
    endtask

    task automatic wen();
        cmd(8, {`FSC_OP_WRITE_ENABLE, 24'h0});
        check(st[1], 1'b1);
    endtask

    // Polls the busy flag before trusting the read-back
    task automatic idle(input logic [7:0] e);
        repeat (20)
        begin
            rd();
            if (rx[0] === 1'b0)
                break;
        end
        check(rx[7:0], e);
        check(st, e);
    endtask

    task automatic write_status_cmd(input logic [7:0] sv, input logic [7:0] cv, input logic lg);
        wen();
        cmd(lg ? 24 : 16, {`FSC_OP_WRITE_STATUS, sv, cv, 8'h0});
        check(st[0], 1'b1);
        rd();
        // First byte: a slow host may outlast the write cycle by the second
        check(rx[8], 1'b1);
        idle({sv[7:2], 2'b00});
    endtask

    task automatic pe(input logic [7:0] op, input int n, input logic p, input int go);
        int n0;
        logic [23:0] a;
        n0 = n_start;
        a = 24'($urandom);
        @(posedge i_clk);
        i_prot <= p;
        cmd(n, {op, a});
        check(n_start - n0, go);
        if (go == 0)
        begin
            check(st[1:0], 2'b00);
            return;
        end
        check(pe_cmd, op);
        if (n == 32)
            check(pe_addr, a);
        rd();
        check(rx[0], 1'b1);
        @(posedge i_clk);
        i_done <= 1'b1;
        @(posedge i_clk);
        i_done <= 1'b0;
        repeat (3) @(posedge i_clk);
        check(st, 8'h00);
    endtask

    // ********************************
    // Main sequence
    // ********************************
    initial
    begin
        i_rst = 1'b1;
        i_wp = 1'b1;
        i_pause = 1'b1;
        i_prot = 1'b0;
        i_done = 1'b0;
        n_fail = 0;
        total_checks = 0;
        exp_bot = 1'b0;
        exp_dc = 1'b0;
        void'($urandom(32'he5f2));
        repeat (8) @(posedge i_clk);
        i_rst <= 1'b0;
        repeat (3) @(posedge i_clk);
        check(st, 8'h00);
        check(cf, 2'b00);
        check({dd, qd}, 8'h46);
        check(so_oe_n, 1'b1);
        rd();
        check(rx[23:0], 24'hFF0000);
        for (int k = 0; k < 6; k++)
        begin
            s = 8'($urandom);
            c = 8'($urandom);
            u_fsc_host.half = (k == 3) ? 240 : 80;
            write_status_cmd(s, c, k[0]);
            if (k[0])
            begin
                exp_bot = exp_bot | c[3];
                exp_dc = c[6];
            end
            check(cf, {exp_dc, exp_bot});
            check({dd, qd}, dummies(exp_dc));
        end
        write_status_cmd(8'h00, 8'h48, 1'b1);
        check({dd, qd}, dummies(1'b1));
        write_status_cmd(8'h00, 8'h00, 1'b1);
        check(cf, 2'b01);
        write_status_cmd(8'h80, 8'h00, 1'b0);
        @(posedge i_clk);
        i_wp <= 1'b0;
        repeat (3) @(posedge i_clk);
        check(lock, 1'b1);
        wen();
        cmd(16, {`FSC_OP_WRITE_STATUS, 8'h3C, 16'h0});
        check(st, 8'h82);
        @(posedge i_clk);
        i_wp <= 1'b1;
        write_status_cmd(8'hC0, 8'h00, 1'b0);
        @(posedge i_clk);
        i_wp <= 1'b0;
        i_pause <= 1'b0;
        repeat (3) @(posedge i_clk);
        check({lock, pause_act}, 2'b00);
        write_status_cmd(8'h00, 8'h00, 1'b0);
        check(pause_act, 1'b1);
        @(posedge i_clk);
        i_wp <= 1'b1;
        i_pause <= 1'b1;
        wen();
        cmd(20, {`FSC_OP_WRITE_STATUS, 8'h3C, 16'h0});
        check(st, 8'h02);
        pe(`FSC_OP_PAGE_PROGRAM, 32, 1'b1, 0);
        pe(`FSC_OP_PAGE_PROGRAM, 32, 1'b0, 0);
        foreach (ops[i])
        begin
            wen();
            pe(ops[i], 32, 1'b0, 1);
        end
        write_status_cmd(8'h04, 8'h00, 1'b0);
        wen();
        pe(`FSC_OP_CHIP_ERASE, 8, 1'b0, 0);
        check(st, 8'h04);
        write_status_cmd(8'h00, 8'h00, 1'b0);
        wen();
        pe(`FSC_OP_CHIP_ERASE, 8, 1'b0, 1);
        stop_test();
    end

    initial
    begin
        #2000000;
        n_fail++;
        stop_test();
    end
endmodule
